/* File: rtl/dwb_host.sv */
// Controller end: register file, link clock divider and write sequencer
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dwb_host
	import dwb_pkg::*;
(
	// Clock and reset
	input  logic        core_clk,
	input  logic        sys_rst,
	// Wishbone slave
	input  logic        wb_cyc,
	input  logic        wb_stb,
	input  logic        wb_we,
	input  logic [7:0]  wb_adr,
	input  logic [31:0] wb_dat_w,
	input  logic [3:0]  wb_sel,
	output logic [31:0] wb_dat_r,
	output logic        wb_ack,
	// Link
	dwb_if.host         lnk
);
	logic [31:0] cfg_q;
	logic [31:0] cmd_q;
	logic [31:0] dat_q [4];
	logic [15:0] mask_q;
	logic        run_q;
	logic        err_q;
	logic [7:0]  t_q;
	logic [2:0]  dv_q;
	logic        ck_q;
	logic        cmd_o_q;
	logic        a10_q;
	logic        a12_q;
	logic [1:0]  ba_q;
	logic [9:0]  col_q;
	logic [31:0] dq_q;
	logic [3:0]  dm_q;
	logic        oe_q;
	logic        req;
	logic        wr;
	logic        fall;
	logic        wr_cmd;
	logic        bad;
	logic [1:0]  bm;
	logic        pre2;
	logic [7:0]  wl;
	logic [7:0]  sp;
	logic [7:0]  s1;
	logic [7:0]  len;
	logic [7:0]  pre;
	logic [7:0]  gap;
	logic [7:0]  end_t;
	logic        twin;
	logic        in0;
	logic        in1;
	logic        pre0;
	logic        pre1;
	logic [1:0]  idx;
	logic        is_cmd;
	logic        is_2nd;
	logic [31:0] rd;
	logic [31:0] wmask;

	//--------------------------------------------------------------
	// Bus decode
	//--------------------------------------------------------------
	assign req    = wb_cyc & wb_stb & ~wb_ack;
	assign wr     = req & wb_we;
	assign wr_cmd = wr & (wb_adr == REG_CMD);
	assign wmask  = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};

	// Read mux, unmapped reads as zero
	always_comb
	begin
		rd = 32'h0000_0000;
		case (wb_adr)
			REG_CFG:       rd = cfg_q;
			REG_CMD:       rd = cmd_q;
			REG_DAT:       rd = dat_q[0];
			REG_DAT + 8'h4: rd = dat_q[1];
			REG_DAT + 8'h8: rd = dat_q[2];
			REG_DAT + 8'hc: rd = dat_q[3];
			REG_MASK:      rd = {16'h0000, mask_q};
			REG_STAT:      rd = {30'h0, err_q, run_q};
			default:       rd = 32'h0000_0000;
		endcase
	end

	// Acknowledge one cycle after the request, read data with it
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			wb_ack   <= 1'b0;
			wb_dat_r <= 32'h0000_0000;
		end
		else
		begin
			wb_ack   <= req;
			wb_dat_r <= rd;
		end
	end

	//--------------------------------------------------------------
	// Register writes
	//--------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cfg_q  <= CFG_RST;
			mask_q <= 16'hffff;
		end
		else
		begin
			if (wr && wb_adr == REG_CFG)
				cfg_q <= (cfg_q & ~wmask) | (wb_dat_w & wmask);
			if (wr && wb_adr == REG_MASK)
				mask_q <= (mask_q & ~wmask[15:0]) | (wb_dat_w[15:0] & wmask[15:0]);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_dat
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
					dat_q[gi] <= 32'h0000_0000;
				else if (wr && wb_adr == REG_DAT + 8'(4 * gi))
					dat_q[gi] <= (dat_q[gi] & ~wmask) | (wb_dat_w & wmask);
			end
		end
	endgenerate

	//--------------------------------------------------------------
	// Link clock divider
	//--------------------------------------------------------------
	assign fall = ck_q & (dv_q == 3'(CK_HALF - 1));

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			dv_q <= 3'h0;
			ck_q <= 1'b0;
		end
		else if (dv_q == 3'(CK_HALF - 1))
		begin
			dv_q <= 3'h0;
			ck_q <= ~ck_q;
		end
		else
			dv_q <= dv_q + 3'h1;
	end

	//--------------------------------------------------------------
	// Write schedule in link clocks counted from the first command
	//--------------------------------------------------------------
	assign bm    = cfg_q[CF_BM +: 2];
	assign pre2  = cfg_q[CF_PRE2];
	assign wl    = 8'(cfg_q[CF_AL +: 5]) + 8'(cfg_q[CF_CWL +: 5]);
	assign twin  = cmd_q[CM_TWIN];
	assign sp    = 8'(cmd_q[CM_SP +: 5]);
	assign s1    = wl + sp;
	assign len   = ((bm == BM_BC4) || (bm == BM_OTF && !cmd_q[CM_A12])) ?
		8'(LEN_BC4) : 8'(LEN_BL8);
	assign gap   = (bm == BM_BC4) ? 8'(GAP_FIX) : 8'(GAP_OTF);
	assign pre   = pre2 ? 8'h2 : 8'h1;
	// Recovery is the tWR field counted from gap clocks after the last burst start, two clocks past the last beat for an OTF chop
	assign end_t = (twin ? sp : 8'h00) + wl + gap + 8'(cfg_q[CF_TWR +: 5]);
	assign in0   = (t_q >= wl) && (t_q < wl + len);
	assign in1   = twin && (t_q >= s1) && (t_q < s1 + len);
	assign pre0  = (t_q + pre >= wl) && (t_q < wl);
	assign pre1  = twin && (t_q + pre >= s1) && (t_q < s1);
	assign idx   = in0 ? 2'(t_q - wl) : 2'(t_q - s1);
	assign is_cmd = run_q && (t_q == 8'h00 || (twin && t_q == sp));
	assign is_2nd = twin && t_q == sp;

	// Refusal of settings the link does not allow
	assign bad = (pre2 && cfg_q[CF_CWL +: 5] <= 5'(CWL_LOW)) ||
		(wb_dat_w[CM_TWIN] && wb_dat_w[CM_SP +: 5] < 5'(SP_MIN)) ||
		(pre2 && wb_dat_w[CM_TWIN] && wb_dat_w[CM_SP +: 5] == 5'(SP_BAD)) ||
		(wl < 8'(WL_MIN)) || run_q;

	// Start, step on each link clock fall, and error flag
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cmd_q <= 32'h0000_0000;
			run_q <= 1'b0;
			err_q <= 1'b0;
			t_q   <= 8'h00;
		end
		else
		begin
			if (wr_cmd && bad)
				err_q <= 1'b1;
			else if (wr && wb_adr == REG_STAT && wb_dat_w[1])
				err_q <= 1'b0;
			if (wr_cmd && !bad)
			begin
				cmd_q <= wb_dat_w;
				run_q <= 1'b1;
				t_q   <= 8'h00;
			end
			else if (run_q && fall)
			begin
				t_q <= t_q + 8'h01;
				if (t_q == end_t)
					run_q <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------
	// Link outputs, changed as the link clock falls
	//--------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cmd_o_q <= 1'b0;
			a10_q   <= 1'b0;
			a12_q   <= 1'b0;
			ba_q    <= 2'h0;
			col_q   <= 10'h000;
			dq_q    <= 32'h0000_0000;
			dm_q    <= 4'hf;
			oe_q    <= 1'b0;
		end
		else if (fall)
		begin
			cmd_o_q <= is_cmd;
			a10_q   <= is_cmd & cmd_q[CM_A10];
			a12_q   <= is_cmd & cmd_q[CM_A12];
			ba_q    <= cmd_q[CM_BA +: 2] + {1'b0, is_2nd};
			col_q   <= cmd_q[CM_COL +: 10];
			dq_q    <= (run_q && (in0 || in1)) ? dat_q[idx] : 32'h0000_0000;
			dm_q    <= (run_q && (in0 || in1)) ? mask_q[idx*4 +: 4] : 4'hf;
			oe_q    <= run_q && (in0 || in1 || pre0 || pre1);
		end
	end

	assign lnk.ck    = ck_q;
	assign lnk.cmd   = cmd_o_q;
	assign lnk.a10   = a10_q;
	assign lnk.a12   = a12_q;
	assign lnk.ba    = ba_q;
	assign lnk.col   = col_q;
	assign lnk.dq    = dq_q;
	assign lnk.dm_n  = dm_q;
	assign lnk.dq_oe = oe_q;
endmodule // dwb_host

/* File: rtl/dwb_pkg.sv */
// Constants and types shared by both ends of the write-burst link
//--------------------------------------------------------------
//--------------------------------------------------------------
package dwb_pkg;
	// Burst mode and organisation codes
	localparam logic [1:0] BM_BL8  = 2'h0;
	localparam logic [1:0] BM_OTF  = 2'h1;
	localparam logic [1:0] BM_BC4  = 2'h2;
	localparam logic [1:0] ORG_X4  = 2'h0;
	// Link timing in link clocks (two beats per clock)
	localparam int         LEN_BL8 = 4;
	localparam int         LEN_BC4 = 2;
	localparam int         GAP_OTF = 4;
	localparam int         GAP_FIX = 2;
	localparam int         SP_MIN  = 4;
	localparam int         SP_BAD  = 5;
	localparam int         CWL_LOW = 9;
	localparam int         WL_MIN  = 2;
	localparam int         DL_DEP  = 32;
	// Link clock made by the host divider
	localparam int         CLK_NS  = 5;
	localparam int         CK_NS   = 40;
	localparam int         CK_HALF = CK_NS / (2 * CLK_NS);
	// Register byte offsets
	localparam logic [7:0] REG_CFG  = 8'h00;
	localparam logic [7:0] REG_CMD  = 8'h04;
	localparam logic [7:0] REG_DAT  = 8'h08;
	localparam logic [7:0] REG_MASK = 8'h18;
	localparam logic [7:0] REG_STAT = 8'h1c;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	// Configuration fields
	localparam int         CF_BM   = 0;
	localparam int         CF_PRE2 = 2;
	localparam int         CF_AL   = 3;
	localparam int         CF_CWL  = 8;
	localparam int         CF_TWR  = 13;
	// Command fields
	localparam int         CM_COL  = 0;
	localparam int         CM_BA   = 10;
	localparam int         CM_A10  = 12;
	localparam int         CM_A12  = 13;
	localparam int         CM_TWIN = 14;
	localparam int         CM_SP   = 16;
	// Pending write held in the latency line
	typedef struct packed {
		logic       v;
		logic       bc4;
		logic       ap;
		logic [1:0] ba;
		logic [9:0] col;
	} dwb_cmd_s;
endpackage

/* File: rtl/dwb_if.sv */
// Link between the memory controller and the write-burst device
`timescale 1ns/1ps
interface dwb_if;
	logic        ck;
	logic        cmd;
	logic        a10;
	logic        a12;
	logic [1:0]  ba;
	logic [9:0]  col;
	logic [31:0] dq;
	logic [3:0]  dm_n;
	logic        dq_oe;
	modport host (output ck, cmd, a10, a12, ba, col, dq, dm_n, dq_oe);
	modport dev  (input  ck, cmd, a10, a12, ba, col, dq, dm_n, dq_oe);
endinterface

/* File: rtl/dwb_sync.sv */
// Two-flop synchroniser for static configuration levels
`timescale 1ns/1ps
module dwb_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  logic         clk,
	input  logic         rst,
	// Levels
	input  logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] m_q;

	// First stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			m_q  <= '0;
			dout <= '0;
		end
		else
		begin
			m_q  <= din;
			dout <= m_q;
		end
	end
endmodule // dwb_sync

/* File: rtl/dwb_dev.sv */
// Device end: write latency line, burst engine, masking and auto precharge
`timescale 1ns/1ps
module dwb_dev
	import dwb_pkg::*;
(
	// Link, clocks the whole device
	dwb_if.dev          lnk,
	input  logic        sys_rst,
	// Configuration levels
	input  logic [1:0]  burst_mode,
	input  logic [4:0]  add_lat,
	input  logic [4:0]  cas_wlat,
	input  logic        dm_en,
	input  logic        dbi_en,
	input  logic        crc_en,
	input  logic [1:0]  org,
	// Array write port
	output logic        mem_we,
	output logic [1:0]  mem_ba,
	output logic [9:0]  mem_col,
	output logic [31:0] mem_wdata,
	output logic [3:0]  mem_be,
	// Bank and CRC status
	output logic        prech,
	output logic [1:0]  prech_ba,
	output logic        crc_persist
);
	logic [16:0] cfg_s;
	logic [1:0]  bm;
	logic [4:0]  al;
	logic [4:0]  cwl;
	logic        dm_s;
	logic        dbi_s;
	logic        crc_s;
	logic [1:0]  org_s;
	logic [5:0]  wl;
	logic [4:0]  wl_ix;
	dwb_cmd_s    new_e;
	dwb_cmd_s    dl_q [DL_DEP];
	dwb_cmd_s    dl_d [DL_DEP];
	dwb_cmd_s    cur_q;
	dwb_cmd_s    cmd_r_q;
	dwb_cmd_s    sel;
	logic        act_q;
	logic [1:0]  cnt_q;
	logic [1:0]  idx;
	logic        live;
	logic        last;
	logic        mask_on;
	logic [31:0] wdat;

	dwb_sync #(.W(17)) u_sync (
		.clk  (lnk.ck),
		.rst  (sys_rst),
		.din  ({burst_mode, add_lat, cas_wlat, dm_en, dbi_en, crc_en, org}),
		.dout (cfg_s)
	);

	// Configuration fields
	assign {bm, al, cwl, dm_s, dbi_s, crc_s, org_s} = cfg_s;
	assign wl    = {1'b0, al} + {1'b0, cwl};
	assign wl_ix = 5'(wl - 6'(WL_MIN));

	// Command decode at the command edge
	assign new_e.v   = 1'b1;
	assign new_e.bc4 = (bm == BM_BC4) | ((bm == BM_OTF) & ~lnk.a12);
	assign new_e.ap  = lnk.a10;
	assign new_e.ba  = lnk.ba;
	assign new_e.col = lnk.col;

	// Command held one clock, so entry at WL-2 leaves on the data edge
	always_ff @(posedge lnk.ck)
	begin
		if (sys_rst)
			cmd_r_q <= '0;
		else
			cmd_r_q <= lnk.cmd ? new_e : '0;
	end

	// Latency line: entry lands so it leaves on the data edge
	genvar gi;
	generate
		for (gi = 0; gi < DL_DEP; gi++)
		begin : g_dl
			if (gi == DL_DEP - 1)
			begin : g_top
				assign dl_d[gi] = (cmd_r_q.v && wl_ix == 5'(gi)) ? cmd_r_q : '0;
			end
			else
			begin : g_mid
				assign dl_d[gi] = (cmd_r_q.v && wl_ix == 5'(gi)) ? cmd_r_q : dl_q[gi+1];
			end
		end
	endgenerate

	always_ff @(posedge lnk.ck)
	begin
		if (sys_rst)
			dl_q <= '{default: '0};
		else
			dl_q <= dl_d;
	end

	// Burst engine: a new burst takes over on its first clock
	assign sel  = dl_q[0].v ? dl_q[0] : cur_q;
	assign idx  = dl_q[0].v ? 2'h0 : cnt_q;
	assign live = dl_q[0].v | act_q;
	assign last = live & (idx == (sel.bc4 ? 2'(LEN_BC4 - 1) : 2'(LEN_BL8 - 1)));

	always_ff @(posedge lnk.ck)
	begin
		if (sys_rst)
		begin
			act_q <= 1'b0;
			cnt_q <= 2'h0;
			cur_q <= '0;
		end
		else
		begin
			act_q <= live & ~last;
			cnt_q <= idx + 2'h1;
			cur_q <= sel;
		end
	end

	// Mask and inversion share the pin, never both active
	assign mask_on = dm_s & ~dbi_s & (org_s != ORG_X4);

	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wdat[gi*8 +: 8] = (dbi_s && (org_s != ORG_X4) && !lnk.dm_n[gi]) ?
				~lnk.dq[gi*8 +: 8] : lnk.dq[gi*8 +: 8];
		end
	endgenerate

	// Array write port, two beats per link clock
	always_ff @(posedge lnk.ck)
	begin
		if (sys_rst)
		begin
			mem_we    <= 1'b0;
			mem_ba    <= 2'h0;
			mem_col   <= 10'h000;
			mem_wdata <= 32'h0000_0000;
			mem_be    <= 4'h0;
		end
		else
		begin
			mem_we    <= live;
			mem_ba    <= sel.ba;
			mem_col   <= sel.col + {7'h00, idx, 1'b0};
			mem_wdata <= wdat;
			mem_be    <= mask_on ? lnk.dm_n : 4'hf;
		end
	end

	// Auto precharge in the same clock as the last beat's array write, CRC mode flag
	always_ff @(posedge lnk.ck)
	begin
		if (sys_rst)
		begin
			prech       <= 1'b0;
			prech_ba    <= 2'h0;
			crc_persist <= 1'b0;
		end
		else
		begin
			prech       <= last & sel.ap;
			prech_ba    <= sel.ba;
			crc_persist <= crc_s & dm_s;
		end
	end
endmodule // dwb_dev

/* File: verif/dwb_chk.sv */
// Concurrent checks on the write-burst link and the device array port
`timescale 1ns/1ps
module dwb_chk
	import dwb_pkg::*;
(
	// Link
	input logic        ck,
	input logic        sys_rst,
	input logic        cmd,
	input logic        a10,
	input logic        a12,
	input logic [1:0]  ba,
	input logic [9:0]  col,
	input logic [31:0] dq,
	input logic [3:0]  dm_n,
	input logic        dq_oe,
	// Device configuration
	input logic [1:0]  burst_mode,
	input logic [4:0]  add_lat,
	input logic [4:0]  cas_wlat,
	input logic        dm_en,
	input logic        dbi_en,
	input logic        crc_en,
	input logic [1:0]  org,
	// Array port and status
	input logic        mem_we,
	input logic [1:0]  mem_ba,
	input logic [9:0]  mem_col,
	input logic [31:0] mem_wdata,
	input logic [3:0]  mem_be,
	input logic        prech,
	input logic [1:0]  prech_ba,
	input logic        crc_persist
);
	//--------------------------------------------
	// Command tracker
	//--------------------------------------------
	logic [5:0] since_q;
	logic [5:0] since_d;
	logic [1:0] ba_q;
	logic [9:0] col_q;
	logic       ap_q;
	logic       bc4_q;
	wire  [5:0] wl   = 6'(add_lat) + 6'(cas_wlat);
	wire  [5:0] blen = bc4_q ? 6'h2 : 6'h4;
	wire        mask = dm_en && !dbi_en && org != ORG_X4;
	wire        chop = burst_mode == BM_BC4 || (burst_mode == BM_OTF && !a12);
	assign since_d = cmd ? 6'h1 : since_q + 6'(since_q != 6'h3f);
	// Counts link clocks since the last command and keeps its fields
	always_ff @(posedge ck)
	begin
		since_q <= sys_rst ? 6'h3f : since_d;
		if (cmd)
		begin
			ba_q  <= ba;
			col_q <= col;
			ap_q  <= a10;
			bc4_q <= chop;
		end
	end
	default clocking cb @(posedge ck); endclocking
	default disable iff (sys_rst);
	//--------------------------------------------
	// Properties
	//--------------------------------------------
	property p_gap; cmd |=> !cmd [*3]; endproperty
	a_gap: assert property (p_gap) else $error("commands too close");
	property p_oe; since_q == wl |-> dq_oe; endproperty
	a_oe: assert property (p_oe) else $error("no data drive at latency");
	property p_start; since_q == wl + 6'h1 |-> mem_we && mem_col == col_q && mem_ba == ba_q; endproperty
	a_start: assert property (p_start) else $error("first write late or wrong");
	property p_chop; since_q == wl + 6'h3 |-> mem_we == !bc4_q; endproperty
	a_chop: assert property (p_chop) else $error("burst length wrong");
	property p_prech; since_q == wl + blen |-> prech == ap_q && (!ap_q || prech_ba == ba_q); endproperty
	a_prech: assert property (p_prech) else $error("auto precharge wrong");
	property p_mask; mem_we |-> mem_be == (mask ? $past(dm_n) : 4'hf); endproperty
	a_mask: assert property (p_mask) else $error("lane enables wrong");
	property p_data; mem_we && !dbi_en |-> mem_wdata == $past(dq); endproperty
	a_data: assert property (p_data) else $error("stored data wrong");
	property p_last; prech |-> mem_we; endproperty
	a_last: assert property (p_last) else $error("precharge before burst end");
	property p_crc; ($stable(crc_en) && $stable(dm_en)) [*4] |-> crc_persist == (crc_en && dm_en); endproperty
	a_crc: assert property (p_crc) else $error("crc mode wrong");
endmodule // dwb_chk

/* File: verif/ddr4_write_burst_control_test.sv */
// Self-checking bench for the write-burst controller and device pair
`timescale 1ns/1ps
module ddr4_write_burst_control_test
	import dwb_pkg::*;
;
	//--------------------------------------------
	// Signals and instances
	//--------------------------------------------
	typedef struct packed {
		logic [1:0]  bm;
		logic        a10;
		logic        a12;
		logic        dm;
		logic        dbi;
		logic [1:0]  org;
		logic [3:0]  nwe;
		logic [3:0]  be;
		logic [31:0] wd;
	} dwb_row_s;
	dwb_row_s    rows [6] = '{
		'{BM_BL8, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 4'h4, 4'ha, 32'h5a00_0000},
		'{BM_OTF, 1'b1, 1'b0, 1'b1, 1'b0, 2'h2, 4'h2, 4'ha, 32'h5a00_0000},
		'{BM_OTF, 1'b0, 1'b1, 1'b0, 1'b0, 2'h1, 4'h4, 4'hf, 32'h5a00_0000},
		'{BM_BC4, 1'b1, 1'b1, 1'b1, 1'b0, 2'h1, 4'h2, 4'ha, 32'h5a00_0000},
		'{BM_BL8, 1'b0, 1'b0, 1'b1, 1'b0, ORG_X4, 4'h4, 4'hf, 32'h5a00_0000},
		'{BM_BL8, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 4'h4, 4'hf, 32'h5aff_00ff}};
	logic        core_clk = 1'b0;
	logic        host_rst = 1'b1;
	logic        dev_rst = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_dat_w = 32'h0;
	logic [3:0]  wb_sel = 4'hf;
	logic [1:0]  burst_mode = 2'h0;
	logic [4:0]  add_lat = 5'h0;
	logic [4:0]  cas_wlat = 5'h0;
	logic        dm_en = 1'b0;
	logic        dbi_en = 1'b0;
	logic        crc_en = 1'b0;
	logic [1:0]  org = 2'h1;
	logic        wb_ack, mem_we, prech, crc_persist;
	logic [1:0]  mem_ba, prech_ba;
	logic [9:0]  mem_col, col0;
	logic [3:0]  mem_be, be0;
	logic [31:0] wb_dat_r, mem_wdata, wd0, rd;
	int          n_errors = 0, checked = 0, n_we = 0, n_pr = 0;
	dwb_if lnk();
	dwb_host dwb_host_inst (.core_clk, .sys_rst(host_rst), .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_dat_w,
		.wb_sel, .wb_dat_r, .wb_ack, .lnk(lnk));
	dwb_dev dwb_dev_inst (.lnk(lnk), .sys_rst(dev_rst), .burst_mode, .add_lat, .cas_wlat, .dm_en, .dbi_en,
		.crc_en, .org, .mem_we, .mem_ba, .mem_col, .mem_wdata, .mem_be, .prech, .prech_ba, .crc_persist);
	dwb_chk dwb_chk_inst (.ck(lnk.ck), .sys_rst(dev_rst), .cmd(lnk.cmd), .a10(lnk.a10), .a12(lnk.a12),
		.ba(lnk.ba), .col(lnk.col), .dq(lnk.dq), .dm_n(lnk.dm_n), .dq_oe(lnk.dq_oe), .burst_mode, .add_lat,
		.cas_wlat, .dm_en, .dbi_en, .crc_en, .org, .mem_we, .mem_ba, .mem_col, .mem_wdata, .mem_be, .prech,
		.prech_ba, .crc_persist);
	// Core clock
	always #2.5 core_clk = ~core_clk;
	// Count array writes and precharges, keep the first beat pair
	always @(posedge lnk.ck)
	begin
		if (mem_we === 1'b1 && n_we == 0)
		begin
			wd0 = mem_wdata;
			be0 = mem_be;
			col0 = mem_col;
		end
		n_we += int'(mem_we === 1'b1);
		n_pr += int'(prech === 1'b1);
	end
	//--------------------------------------------
	// Tasks
	//--------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge core_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat_w <= dat;
		do
			@(posedge core_clk);
		while (wb_ack !== 1'b1);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic setcfg(input logic [1:0] bm, input logic p2, input logic [4:0] al, input logic [4:0] cwl,
		input logic dm, input logic dbi, input logic [1:0] og);
		@(posedge core_clk);
		burst_mode <= bm;
		add_lat <= al;
		cas_wlat <= cwl;
		dm_en <= dm;
		dbi_en <= dbi;
		org <= og;
		wb(1'b1, REG_CFG, {14'h0, 5'h4, cwl, al, p2, bm});
		repeat (32) @(posedge core_clk);
	endtask
	task automatic go(input logic [31:0] cw, input int nwe, input int npr, input logic err);
		n_we = 0;
		n_pr = 0;
		wb(1'b1, REG_CMD, cw);
		do
			wb(1'b0, REG_STAT, 32'h0);
		while (rd[0] !== 1'b0);
		chk("writes", n_we, nwe);
		chk("precharges", n_pr, npr);
		chk("error", rd[1], err);
		if (err)
			wb(1'b1, REG_STAT, 32'h2);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Cut a hang short
	initial
	begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		summarize();
	end
	// Main sequence
	initial
	begin
		repeat (16) @(posedge core_clk);
		host_rst <= 1'b0;
		repeat (40) @(posedge core_clk);
		@(posedge lnk.ck);
		dev_rst <= 1'b0;
		crc_en <= 1'b1;
		wb(1'b0, REG_CFG, 32'h0);
		chk("cfg reset", rd, CFG_RST);
		wb(1'b0, REG_MASK, 32'h0);
		chk("mask reset", rd, 32'hffff);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, REG_MASK, 32'h5a5a);
		for (int k = 0; k < 4; k++)
			wb(1'b1, REG_DAT + 8'(4 * k), 32'h5a00_0000 | k);
		foreach (rows[i])
		begin
			setcfg(rows[i].bm, 1'b0, 5'h2, 5'h7, rows[i].dm, rows[i].dbi, rows[i].org);
			go({18'h0, rows[i].a12, rows[i].a10, 2'h1, 10'h10}, rows[i].nwe, rows[i].a10, 1'b0);
			chk("column", col0, 10'h10);
			chk("lanes", be0, rows[i].be);
			chk("data", wd0, rows[i].wd);
			chk("crc mode", crc_persist, rows[i].dm);
		end
		setcfg(BM_OTF, 1'b0, 5'h2, 5'h7, 1'b1, 1'b0, 2'h1);
		go({11'h0, 5'h4, 4'h7, 2'h1, 10'h20}, 8, 2, 1'b0);
		setcfg(BM_BL8, 1'b1, 5'h0, 5'ha, 1'b1, 1'b0, 2'h1);
		go({11'h0, 5'h6, 4'h4, 2'h0, 10'h0}, 8, 0, 1'b0);
		go({11'h0, 5'h5, 4'h4, 2'h0, 10'h0}, 0, 0, 1'b1);
		go({11'h0, 5'h3, 4'h4, 2'h0, 10'h0}, 0, 0, 1'b1);
		setcfg(BM_BL8, 1'b1, 5'h0, 5'h9, 1'b1, 1'b0, 2'h1);
		go({22'h0, 10'h0}, 0, 0, 1'b1);
		wb(1'b0, REG_STAT, 32'h0);
		chk("stat clear", rd, 32'h0);
		// Host reset after a configuration write brings the registers back
		wb(1'b1, REG_CFG, 32'h0000_0155);
		@(posedge core_clk);
		host_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		host_rst <= 1'b0;
		wb(1'b0, REG_CFG, 32'h0);
		chk("cfg after reset", rd, CFG_RST);
		summarize();
	end
endmodule // ddr4_write_burst_control_test
